// >>> ips_top.sv
// Interrupt priority select registers with level arbitration and nesting control.
`timescale 1ns/1ps
`include "ips_consts.svh"

module ips_top (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Register port.
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Interrupt sources, indexed by source number.
	input wire logic [7:0] SRC_REQ,
	// Core handshake.
	input wire logic IRQ_ACK,
	input wire logic IRQ_RETI,
	output logic ARB_VALID,
	output logic [2:0] ARB_SRC,
	output logic [1:0] ARB_LEVEL,
	// Per-source levels, two bits per source.
	output logic [15:0] SRC_LEVELS,
	// Event interrupt.
	output logic IRQ_OUT
);

	// Priority select state.
	logic [7:0] prio_hi_r;
	logic [7:0] prio_lo_r;
	logic spi_hi_r;

	// Field views, named after the bits they hold.
	logic adc_level_hi;
	logic timer2_level_hi;
	logic serial0_level_hi;
	logic serial0_level_hi_alias;
	logic timer1_level_hi;
	logic ext1_level_hi;
	logic timer0_level_hi;
	logic ext0_level_hi;
	logic adc_level_lo;
	logic timer2_level_lo;
	logic serial0_level_lo;
	logic timer1_level_lo;
	logic ext1_level_lo;
	logic timer0_level_lo;
	logic ext0_level_lo;
	logic serial_periph_level_hi;

	// Arbitration.
	logic [7:0] src_hi;
	logic [7:0] src_lo;
	ips_pkg::ips_level_t src_level [8];
	logic win_valid;
	logic [2:0] win_src;
	ips_pkg::ips_level_t win_level;
	logic arb_valid_r;
	logic [2:0] arb_src_r;
	ips_pkg::ips_level_t arb_level_r;

	// Nesting: one in-service bit per level.
	logic [3:0] in_service_r;
	logic [3:0] in_service_nxt;
	logic [2:0] svc_top;
	logic svc_active;
	ips_pkg::ips_level_t svc_level;

	// Events and interrupt.
	logic [7:0] evt_stat_r;
	logic [7:0] evt_mask_r;
	logic [7:0] evt_set;
	logic [7:0] evt_clr;

	// Register port decode.
	logic wr_prio_hi;
	logic wr_prio_lo;
	logic wr_spi_hi;
	logic wr_evt_stat;
	logic wr_evt_mask;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;

	// The level of one source: the high select bit outranks the low one.
	// Kept as a function so the winner search and the published levels agree.
	function automatic ips_pkg::ips_level_t level_of(input logic hi, input logic lo);
		level_of = {hi, lo};
	endfunction : level_of

	// Highest level whose in-service bit is set; valid flag in the top bit.
	// Scanning upwards leaves the highest set bit in the result.
	function automatic logic [2:0] top_level(input logic [3:0] svc);
		logic [2:0] res;
		res = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (svc[i]) begin
				res = {1'b1, i[1:0]};
			end
		end
		top_level = res;
	endfunction : top_level

	// Field views of the select registers.
	assign adc_level_hi = prio_hi_r[`IPS_BIT_ADC];
	assign timer2_level_hi = prio_hi_r[`IPS_BIT_TIMER2];
	assign serial0_level_hi = prio_hi_r[`IPS_BIT_SERIAL0];
	// A second name for the serial port 0 high bit; both views read the same flop.
	assign serial0_level_hi_alias = serial0_level_hi;
	assign timer1_level_hi = prio_hi_r[`IPS_BIT_TIMER1];
	assign ext1_level_hi = prio_hi_r[`IPS_BIT_EXT1];
	assign timer0_level_hi = prio_hi_r[`IPS_BIT_TIMER0];
	assign ext0_level_hi = prio_hi_r[`IPS_BIT_EXT0];
	assign adc_level_lo = prio_lo_r[`IPS_BIT_ADC];
	assign timer2_level_lo = prio_lo_r[`IPS_BIT_TIMER2];
	assign serial0_level_lo = prio_lo_r[`IPS_BIT_SERIAL0];
	assign timer1_level_lo = prio_lo_r[`IPS_BIT_TIMER1];
	assign ext1_level_lo = prio_lo_r[`IPS_BIT_EXT1];
	assign timer0_level_lo = prio_lo_r[`IPS_BIT_TIMER0];
	assign ext0_level_lo = prio_lo_r[`IPS_BIT_EXT0];
	assign serial_periph_level_hi = spi_hi_r;

	// Register write decode.
	// One register is written per strobe, so an else-if chain is enough.
	always_comb begin
		wr_prio_hi = 1'b0;
		wr_prio_lo = 1'b0;
		wr_spi_hi = 1'b0;
		wr_evt_stat = 1'b0;
		wr_evt_mask = 1'b0;
		if (REG_WR && REG_ADDR == `IPS_OFS_PRIO_HI) begin
			wr_prio_hi = 1'b1;
		end else if (REG_WR && REG_ADDR == `IPS_OFS_PRIO_LO) begin
			wr_prio_lo = 1'b1;
		end else if (REG_WR && REG_ADDR == `IPS_OFS_SPI_HI) begin
			wr_spi_hi = 1'b1;
		end else if (REG_WR && REG_ADDR == `IPS_OFS_EVT_STAT) begin
			wr_evt_stat = 1'b1;
		end else if (REG_WR && REG_ADDR == `IPS_OFS_EVT_MASK) begin
			wr_evt_mask = 1'b1;
		end
	end

	// High select register; the reserved top bit never stores a one.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			prio_hi_r <= `IPS_RST_PRIO;
		end else if (wr_prio_hi) begin
			prio_hi_r <= REG_WDATA & `IPS_PRIO_WMASK;
		end
	end

	// Low select register.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			prio_lo_r <= `IPS_RST_PRIO;
		end else if (wr_prio_lo) begin
			prio_lo_r <= REG_WDATA & `IPS_PRIO_WMASK;
		end
	end

	// Serial peripheral high bit; the other bits of its register belong elsewhere.
	// Only bit 0 is stored here; writes to the other bits of that offset are dropped.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			spi_hi_r <= `IPS_RST_SPI_HI;
		end else if (wr_spi_hi) begin
			spi_hi_r <= REG_WDATA[`IPS_BIT_SPI_HI];
		end
	end

	// Per-source select bits gathered by source number.
	always_comb begin
		src_hi = 8'h00;
		src_lo = 8'h00;
		src_hi[ips_pkg::IPS_SRC_ADC] = adc_level_hi;
		src_hi[ips_pkg::IPS_SRC_TIMER2] = timer2_level_hi;
		src_hi[ips_pkg::IPS_SRC_SERIAL0] = serial0_level_hi_alias;
		src_hi[ips_pkg::IPS_SRC_TIMER1] = timer1_level_hi;
		src_hi[ips_pkg::IPS_SRC_EXT1] = ext1_level_hi;
		src_hi[ips_pkg::IPS_SRC_TIMER0] = timer0_level_hi;
		src_hi[ips_pkg::IPS_SRC_EXT0] = ext0_level_hi;
		src_hi[ips_pkg::IPS_SRC_SPI] = serial_periph_level_hi;
		src_lo[ips_pkg::IPS_SRC_ADC] = adc_level_lo;
		src_lo[ips_pkg::IPS_SRC_TIMER2] = timer2_level_lo;
		src_lo[ips_pkg::IPS_SRC_SERIAL0] = serial0_level_lo;
		src_lo[ips_pkg::IPS_SRC_TIMER1] = timer1_level_lo;
		src_lo[ips_pkg::IPS_SRC_EXT1] = ext1_level_lo;
		src_lo[ips_pkg::IPS_SRC_TIMER0] = timer0_level_lo;
		src_lo[ips_pkg::IPS_SRC_EXT0] = ext0_level_lo;
		// The serial peripheral has no low select bit here, so it sits at level 0 or 2.
		src_lo[ips_pkg::IPS_SRC_SPI] = 1'b0;
	end

	// Levels of all sources.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			src_level[i] = level_of(src_hi[i], src_lo[i]);
		end
	end

	// Source levels published from flops.
	// They change one cycle after a select write, in step with the arbitration result.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			SRC_LEVELS <= 16'h0000;
		end else begin
			for (int i = 0; i < 8; i++) begin
				SRC_LEVELS[2 * i +: 2] <= src_level[i];
			end
		end
	end

	// Highest level in service bounds what may be granted.
	always_comb begin
		svc_top = top_level(in_service_r);
		svc_active = svc_top[2];
		svc_level = svc_top[1:0];
	end

	// Winner: highest level first, lowest source number within a level.
	// The scan runs downwards so that, on equal levels, the lower source number is kept.
	// Requests are levels; a source that drops its request before acknowledge loses.
	// A request is only eligible above the level already in service, so a
	// handler is never preempted by an equal or lower level.
	always_comb begin
		win_valid = 1'b0;
		win_src = 3'h0;
		win_level = 2'h0;
		for (int i = 7; i >= 0; i--) begin
			if (SRC_REQ[i] && (!svc_active || src_level[i] > svc_level)) begin
				if (!win_valid || src_level[i] >= win_level) begin
					win_valid = 1'b1;
					win_src = i[2:0];
					win_level = src_level[i];
				end
			end
		end
	end

	// Registered arbitration result; refreshed every cycle.
	// A request seen at one edge appears on the arbitration outputs right after it.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			arb_valid_r <= 1'b0;
			arb_src_r <= 3'h0;
			arb_level_r <= 2'h0;
		end else begin
			arb_valid_r <= win_valid;
			arb_src_r <= win_src;
			arb_level_r <= win_level;
		end
	end

	// Arbitration outputs come straight from their flops.
	assign ARB_VALID = arb_valid_r;
	assign ARB_SRC = arb_src_r;
	assign ARB_LEVEL = arb_level_r;

	// In-service tracking. A return clears the highest level in service; an
	// acknowledge in the same cycle is taken after that clear.
	// A return with nothing in service changes no bit; it only raises an event.
	always_comb begin
		in_service_nxt = in_service_r;
		if (IRQ_RETI && svc_active) begin
			in_service_nxt[svc_level] = 1'b0;
		end
		if (IRQ_ACK && arb_valid_r) begin
			in_service_nxt[arb_level_r] = 1'b1;
		end
	end

	// One flop per level; a set bit is a handler at that level that has not returned.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			in_service_r <= 4'h0;
		end else begin
			in_service_r <= in_service_nxt;
		end
	end

	// Events: nested grant, return with nothing in service, acknowledge with no winner.
	// A clear is a write of ones to the status offset; zeros leave bits alone.
	always_comb begin
		evt_set = 8'h00;
		evt_set[`IPS_EVT_PREEMPT] = IRQ_ACK && arb_valid_r && svc_active;
		evt_set[`IPS_EVT_RETI_EMPTY] = IRQ_RETI && !svc_active;
		evt_set[`IPS_EVT_ACK_EMPTY] = IRQ_ACK && !arb_valid_r;
		evt_clr = wr_evt_stat ? REG_WDATA : 8'h00;
	end

	// Sticky status; a new event in the clearing cycle survives.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			evt_stat_r <= `IPS_RST_EVT;
		end else begin
			evt_stat_r <= ((evt_stat_r & ~evt_clr) | evt_set) & `IPS_EVT_WMASK;
		end
	end

	// Event mask; only the defined event bits are stored.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			evt_mask_r <= `IPS_RST_EVT;
		end else if (wr_evt_mask) begin
			evt_mask_r <= REG_WDATA & `IPS_EVT_WMASK;
		end
	end

	// The output follows the next status value, so it rises with its status bit.
	// The current mask is used, so a mask write takes effect one cycle later.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(((evt_stat_r & ~evt_clr) | evt_set) & evt_mask_r);
		end
	end

	// Read decode; unmapped addresses read zero.
	// Reserved select bits are masked again, so they read zero whatever the flops hold.
	always_comb begin
		rdata_nxt = 8'h00;
		if (REG_ADDR == `IPS_OFS_PRIO_HI) begin
			rdata_nxt = prio_hi_r & `IPS_PRIO_WMASK;
		end else if (REG_ADDR == `IPS_OFS_PRIO_LO) begin
			rdata_nxt = prio_lo_r & `IPS_PRIO_WMASK;
		end else if (REG_ADDR == `IPS_OFS_SPI_HI) begin
			rdata_nxt = {7'h00, spi_hi_r};
		end else if (REG_ADDR == `IPS_OFS_EVT_STAT) begin
			rdata_nxt = evt_stat_r;
		end else if (REG_ADDR == `IPS_OFS_EVT_MASK) begin
			rdata_nxt = evt_mask_r;
		end else if (REG_ADDR == `IPS_OFS_IN_SERVICE) begin
			rdata_nxt = {4'h0, in_service_r};
		end else if (REG_ADDR == `IPS_OFS_WINNER) begin
			rdata_nxt = {2'h0, arb_valid_r, arb_level_r, arb_src_r};
		end
	end

	// Read data stands only in the cycle after the read strobe.
	// Clearing it outside that slot keeps a stale byte from passing for an answer.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rdata_r <= 8'h00;
		end else if (REG_RD) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign REG_RDATA = rdata_r;

endmodule : ips_top

// >>> ips_consts.svh
// Register offsets, field positions and reset values for the priority select block.
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

// Register offsets on the byte-wide register port.
`define IPS_OFS_SPI_HI 8'hB6
`define IPS_OFS_PRIO_HI 8'hB7
`define IPS_OFS_PRIO_LO 8'hB8
`define IPS_OFS_EVT_STAT 8'hC0
`define IPS_OFS_EVT_MASK 8'hC1
`define IPS_OFS_IN_SERVICE 8'hC2
`define IPS_OFS_WINNER 8'hC3

// Bit positions inside the two priority select registers.
`define IPS_BIT_EXT0 0
`define IPS_BIT_TIMER0 1
`define IPS_BIT_EXT1 2
`define IPS_BIT_TIMER1 3
`define IPS_BIT_SERIAL0 4
`define IPS_BIT_TIMER2 5
`define IPS_BIT_ADC 6
`define IPS_BIT_RSVD 7

// Position of the serial peripheral high-priority bit in its own register.
`define IPS_BIT_SPI_HI 0

// Writable bits of the priority select registers; bit 7 is reserved.
`define IPS_PRIO_WMASK 8'h7F

// Event status bit positions.
`define IPS_EVT_PREEMPT 0
`define IPS_EVT_RETI_EMPTY 1
`define IPS_EVT_ACK_EMPTY 2
`define IPS_EVT_WMASK 8'h07

// Reset values.
`define IPS_RST_PRIO 8'h00
`define IPS_RST_SPI_HI 1'b0
`define IPS_RST_EVT 8'h00

`endif

// >>> ips_pkg.sv
// Types shared by the interrupt priority select block.
package ips_pkg;

	// Two-bit priority level: high select bit above low select bit.
	typedef logic [1:0] ips_level_t;

	// Source numbers; lower number wins among requests at the same level.
	typedef enum logic [2:0] {
		IPS_SRC_EXT0 = 3'h0,
		IPS_SRC_TIMER0 = 3'h1,
		IPS_SRC_EXT1 = 3'h2,
		IPS_SRC_TIMER1 = 3'h3,
		IPS_SRC_SERIAL0 = 3'h4,
		IPS_SRC_TIMER2 = 3'h5,
		IPS_SRC_ADC = 3'h6,
		IPS_SRC_SPI = 3'h7
	} ips_src_t;

endpackage : ips_pkg

// >>> ips_top_properties.sv
// Concurrent checks on the ports of the priority select block, bound into ips_top.
`timescale 1ns/1ps
`include "ips_consts.svh"

module ips_top_props (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Register port.
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Arbitration.
	input wire logic [7:0] SRC_REQ,
	input wire logic ARB_VALID,
	input wire logic [2:0] ARB_SRC,
	input wire logic [1:0] ARB_LEVEL,
	input wire logic [15:0] SRC_LEVELS
);
	logic [7:0] wd_q;
	logic [7:0] wd_qq;
	logic [7:0] req_q;
	logic [6:0] hi_bits;
	logic [6:0] lo_bits;

	// Write data is delayed to line up with the level outputs two cycles on.
	always_ff @(posedge CORE_CLK) begin
		wd_q <= REG_WDATA;
		wd_qq <= wd_q;
		req_q <= SRC_REQ;
	end

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			hi_bits[i] = SRC_LEVELS[2 * i + 1];
			lo_bits[i] = SRC_LEVELS[2 * i];
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	// A single write to one offset, not followed by another write there.
	sequence s_wr_once(logic [7:0] a);
		(REG_WR && REG_ADDR == a) ##1 !(REG_WR && REG_ADDR == a);
	endsequence

	property p_hi_bits;
		s_wr_once(`IPS_OFS_PRIO_HI) |=> hi_bits == wd_qq[6:0];
	endproperty
	a_hi_bits: assert property (p_hi_bits) else $error("high select levels wrong");

	property p_lo_bits;
		s_wr_once(`IPS_OFS_PRIO_LO) |=> lo_bits == wd_qq[6:0];
	endproperty
	a_lo_bits: assert property (p_lo_bits) else $error("low select levels wrong");

	property p_spi_hi;
		s_wr_once(`IPS_OFS_SPI_HI) |=> SRC_LEVELS[15] == wd_qq[0];
	endproperty
	a_spi_hi: assert property (p_spi_hi) else $error("serial periph high level wrong");

	property p_spi_lo;
		SRC_LEVELS[14] == 1'b0;
	endproperty
	a_spi_lo: assert property (p_spi_lo) else $error("serial periph low bit set");

	property p_rsvd_read;
		REG_RD && (REG_ADDR == `IPS_OFS_PRIO_HI || REG_ADDR == `IPS_OFS_PRIO_LO)
			|=> REG_RDATA[7] == 1'b0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read as one");

	property p_rdata_idle;
		!REG_RD |=> REG_RDATA == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

	property p_arb_match;
		ARB_VALID |-> ARB_LEVEL == SRC_LEVELS[2 * ARB_SRC +: 2];
	endproperty
	a_arb_match: assert property (p_arb_match) else $error("winner level mismatch");

	property p_arb_req;
		ARB_VALID |-> req_q[ARB_SRC];
	endproperty
	a_arb_req: assert property (p_arb_req) else $error("winner was not requesting");

	property p_arb_none;
		SRC_REQ == 8'h00 |=> !ARB_VALID;
	endproperty
	a_arb_none: assert property (p_arb_none) else $error("winner without request");
endmodule : ips_top_props

bind ips_top ips_top_props u_props (
	.CORE_CLK(CORE_CLK),
	.SYS_RST(SYS_RST),
	.REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR),
	.REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA),
	.SRC_REQ(SRC_REQ),
	.ARB_VALID(ARB_VALID),
	.ARB_SRC(ARB_SRC),
	.ARB_LEVEL(ARB_LEVEL),
	.SRC_LEVELS(SRC_LEVELS)
);

// >>> tb_ips.sv
// Self-checking bench for the priority select block.
`timescale 1ns/1ps
`include "ips_consts.svh"

module tb;
	logic CORE_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [7:0] SRC_REQ = 8'h00;
	logic IRQ_ACK = 1'b0;
	logic IRQ_RETI = 1'b0;
	logic [7:0] REG_RDATA;
	logic ARB_VALID;
	logic [2:0] ARB_SRC;
	logic [1:0] ARB_LEVEL;
	logic [15:0] SRC_LEVELS;
	logic IRQ_OUT;
	int err_total = 0;
	int checks_done = 0;

	ips_top u_dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SRC_REQ(SRC_REQ), .IRQ_ACK(IRQ_ACK), .IRQ_RETI(IRQ_RETI), .ARB_VALID(ARB_VALID),
		.ARB_SRC(ARB_SRC), .ARB_LEVEL(ARB_LEVEL), .SRC_LEVELS(SRC_LEVELS), .IRQ_OUT(IRQ_OUT));

	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask : cyc

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		chk("read data", {8'h00, REG_RDATA}, {8'h00, exp});
	endtask : rd

	// A one-cycle pulse on the acknowledge (1) or return (0) input.
	task pulse(input bit ack);
		@(posedge CORE_CLK);
		if (ack) IRQ_ACK <= 1'b1;
		else IRQ_RETI <= 1'b1;
		@(posedge CORE_CLK);
		IRQ_ACK <= 1'b0;
		IRQ_RETI <= 1'b0;
	endtask : pulse

	function automatic logic [15:0] lv(logic [7:0] hi, logic [7:0] lo, logic spi);
		logic [15:0] r;
		r = {spi, 15'h0000};
		for (int i = 0; i < 7; i++) begin
			r[2 * i +: 2] = {hi[i], lo[i]};
		end
		return r;
	endfunction : lv

	task t_reset;
		rd(`IPS_OFS_PRIO_HI, 8'h00);
		rd(`IPS_OFS_PRIO_LO, 8'h00);
		rd(`IPS_OFS_SPI_HI, 8'h00);
		rd(`IPS_OFS_EVT_STAT, 8'h00);
		cyc(1);
		chk("read data idle", {8'h00, REG_RDATA}, 16'h0000);
		chk("levels", SRC_LEVELS, 16'h0000);
		chk("irq", {15'h0000, IRQ_OUT}, 16'h0000);
	endtask : t_reset

	task automatic t_regs;
		logic [7:0] hv [4] = '{8'hFF, 8'h2A, 8'h55, 8'h00};
		logic [7:0] lov [4] = '{8'h80, 8'h55, 8'hAA, 8'h7F};
		for (int k = 0; k < 4; k++) begin
			wr(`IPS_OFS_PRIO_HI, hv[k]);
			wr(`IPS_OFS_PRIO_LO, lov[k]);
			cyc(2);
			chk("levels", SRC_LEVELS, lv(hv[k], lov[k], 1'b0));
			rd(`IPS_OFS_PRIO_HI, hv[k] & 8'h7F);
			rd(`IPS_OFS_PRIO_LO, lov[k] & 8'h7F);
		end
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
	endtask : t_regs

	task t_spi;
		wr(`IPS_OFS_PRIO_HI, 8'h00);
		wr(`IPS_OFS_PRIO_LO, 8'h01);
		wr(`IPS_OFS_SPI_HI, 8'hFF);
		SRC_REQ <= 8'h81;
		cyc(2);
		chk("levels", SRC_LEVELS, lv(8'h00, 8'h01, 1'b1));
		chk("winner", {ARB_VALID, ARB_LEVEL, ARB_SRC}, {10'h000, 6'h37});
		rd(`IPS_OFS_SPI_HI, 8'h01);
		wr(`IPS_OFS_SPI_HI, 8'h00);
		cyc(3);
		chk("winner", {ARB_VALID, ARB_LEVEL, ARB_SRC}, {10'h000, 6'h28});
	endtask : t_spi

	// Each row: high select, low select, requests, expected valid/level/source.
	task automatic t_arb;
		logic [7:0] hv [4] = '{8'h00, 8'h00, 8'h02, 8'h42};
		logic [7:0] lov [4] = '{8'h00, 8'h40, 8'h40, 8'h40};
		logic [7:0] rq [4] = '{8'h41, 8'h41, 8'h43, 8'h43};
		logic [5:0] ex [4] = '{6'h20, 6'h2E, 6'h31, 6'h3E};
		for (int k = 0; k < 4; k++) begin
			wr(`IPS_OFS_PRIO_HI, hv[k]);
			wr(`IPS_OFS_PRIO_LO, lov[k]);
			SRC_REQ <= rq[k];
			cyc(3);
			chk("winner", {ARB_VALID, ARB_LEVEL, ARB_SRC}, {10'h000, ex[k]});
		end
		@(posedge CORE_CLK);
		SRC_REQ <= 8'h00;
		cyc(3);
		chk("valid", {15'h0000, ARB_VALID}, 16'h0000);
	endtask : t_arb

	task t_events;
		wr(`IPS_OFS_EVT_MASK, 8'h07);
		pulse(1'b0);
		cyc(2);
		chk("irq", {15'h0000, IRQ_OUT}, 16'h0001);
		rd(`IPS_OFS_EVT_STAT, 8'h02);
		wr(`IPS_OFS_EVT_MASK, 8'h00);
		cyc(2);
		chk("irq masked", {15'h0000, IRQ_OUT}, 16'h0000);
		wr(`IPS_OFS_EVT_STAT, 8'h02);
		rd(`IPS_OFS_EVT_STAT, 8'h00);
		pulse(1'b1);
		cyc(2);
		rd(`IPS_OFS_EVT_STAT, 8'h04);
		wr(`IPS_OFS_EVT_MASK, 8'h04);
		cyc(2);
		chk("irq", {15'h0000, IRQ_OUT}, 16'h0001);
		wr(`IPS_OFS_EVT_STAT, 8'h04);
		cyc(2);
		chk("irq cleared", {15'h0000, IRQ_OUT}, 16'h0000);
	endtask : t_events

	// A granted level blocks itself, a higher level preempts, and returns unwind.
	task automatic t_nest;
		wr(`IPS_OFS_PRIO_HI, 8'h00);
		wr(`IPS_OFS_PRIO_LO, 8'h01);
		wr(`IPS_OFS_EVT_MASK, 8'h01);
		SRC_REQ <= 8'h03;
		cyc(2);
		rd(`IPS_OFS_WINNER, 8'h28);
		pulse(1'b1);
		cyc(2);
		chk("valid in service", {15'h0000, ARB_VALID}, 16'h0000);
		rd(`IPS_OFS_IN_SERVICE, 8'h02);
		wr(`IPS_OFS_PRIO_HI, 8'h02);
		wr(`IPS_OFS_PRIO_LO, 8'h03);
		cyc(2);
		chk("winner", {ARB_VALID, ARB_LEVEL, ARB_SRC}, {10'h000, 6'h39});
		pulse(1'b1);
		cyc(2);
		chk("irq nested", {15'h0000, IRQ_OUT}, 16'h0001);
		rd(`IPS_OFS_IN_SERVICE, 8'h0A);
		rd(`IPS_OFS_EVT_STAT, 8'h01);
		pulse(1'b0);
		cyc(2);
		rd(`IPS_OFS_IN_SERVICE, 8'h02);
		chk("winner", {ARB_VALID, ARB_LEVEL, ARB_SRC}, {10'h000, 6'h39});
		pulse(1'b0);
		SRC_REQ <= 8'h00;
		wr(`IPS_OFS_EVT_STAT, 8'h01);
		cyc(2);
		rd(`IPS_OFS_IN_SERVICE, 8'h00);
		chk("irq cleared", {15'h0000, IRQ_OUT}, 16'h0000);
	endtask : t_nest

	// The whole run needs well under two thousand cycles.
	initial begin
		repeat (5000) @(posedge CORE_CLK);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		t_reset();
		t_regs();
		t_spi();
		t_arb();
		t_events();
		t_nest();
		print_verdict();
	end
endmodule : tb
